// [inc/alert_pkg.sv]
// Operation
// - an out-of-limit reading sets its channel's status flag to one
// - flags are sticky; clear only when condition gone and register read
// - unmasked source holds alert low until its condition is gone and its status register is read
// - a mask bit only blocks alert; the status flag still sets
// - no global alert disable; only mask bits suppress it, per source or first mask bit 7 for all second-status flags
// - monitoring starts when host writes one to bit 0 at 0x40
// - first mask bit 7 blocks alert for every second-status flag
// - first mask bits 6..0 block remote temperature channels 7..1
// - second mask bits 7..4 block fan 4..1 speed faults
// - second mask bit 3 blocks the below fan-on threshold condition
// - second mask bits 2..0 block remote temperature channels 10..8
// - fan drive supports pwm above 20 kHz and at about 1.4 kHz
// - first status bit 7 reads one when any second-status flag is set
// - high limit flags value above it; low limit flags value at or below
package alert_pkg;

  // register offsets
  localparam logic [7:0] REG_PWM_DUTY_BASE = 8'h32;
  localparam logic [7:0] REG_PWM_DUTY_LAST = 8'h35;
  localparam logic [7:0] REG_CONFIG1       = 8'h40;
  localparam logic [7:0] REG_STATUS1       = 8'h41;
  localparam logic [7:0] REG_STATUS2       = 8'h42;
  localparam logic [7:0] REG_LIMIT_BASE    = 8'h44;
  localparam logic [7:0] REG_LIMIT_LAST    = 8'h57;
  localparam logic [7:0] REG_PWM_CFG       = 8'h68;
  localparam logic [7:0] REG_MASK1         = 8'h72;
  localparam logic [7:0] REG_MASK2         = 8'h73;

  // field positions
  localparam int CFG_START_BIT         = 0;
  localparam int MASK1_STATUS2_BIT     = 7;
  localparam int PWM_CFG_LOW_FREQ_BIT  = 0;

  // reset values
  localparam logic [7:0] CONFIG1_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET        = 8'h00;
  localparam logic [7:0] PWM_CFG_RESET     = 8'h00;
  localparam logic [7:0] PWM_DUTY_RESET    = 8'h80;
  localparam logic [7:0] LIMIT_HIGH_RESET  = 8'h7F;
  localparam logic [7:0] LIMIT_LOW_RESET   = 8'h80;
  localparam logic [15:0] LIMIT_RESET_WORD = {LIMIT_HIGH_RESET,
                                              LIMIT_LOW_RESET};

  // serial bus address of this device, value is arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h2C;

  // channel counts
  localparam int NUM_TEMPS = 10;
  localparam int NUM_FANS  = 4;

  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int PWM_STEPS       = 256;
  localparam int PWM_HIGH_MIN_HZ = 20_000;
  localparam int PWM_LOW_HZ      = 1_400;
  localparam logic [7:0] PWM_LOW_DIV =
    8'(CLK_HZ / (PWM_LOW_HZ * PWM_STEPS));

  // serial bus slave states
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_WR_BYTE,
    BUS_WR_ACK,
    BUS_RD_BYTE,
    BUS_RD_ACK,
    BUS_RD_NEXT
  } bus_state_t;

  // register offset window test, used for every ranged block
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // signed reading against its window
  function automatic logic limit_fail(input logic [7:0] value,
                                      input logic [7:0] high,
                                      input logic [7:0] low);
    return ($signed(value) > $signed(high)) ||
           ($signed(value) <= $signed(low));
  endfunction

endpackage

// [design/limit_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module limit_mem (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // byte write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [1:0]  wr_byte_en,
  input  wire logic [7:0]  wr_data,
  // comparison read port
  input  wire logic [3:0]  rd_a_addr,
  output logic      [15:0] rd_a_data,
  // host read port
  input  wire logic [3:0]  rd_b_addr,
  output logic      [15:0] rd_b_data
);
  import alert_pkg::*;

  typedef struct packed {
    logic [NUM_TEMPS-1:0][15:0] word;
    logic [15:0]                rd_a;
    logic [15:0]                rd_b;
  } mem_state_t;

  localparam mem_state_t MEM_RESET = '{word: {NUM_TEMPS{LIMIT_RESET_WORD}},
                                       rd_a: 16'h0000,
                                       rd_b: 16'h0000};

  mem_state_t st;
  mem_state_t next_st;

  // byte-lane writes; out-of-range addresses read as zero
  always_comb begin
    next_st = st;
    if (wr_en && (wr_addr < 4'(NUM_TEMPS))) begin
      if (wr_byte_en[0]) begin
        next_st.word[wr_addr][7:0] = wr_data;
      end
      if (wr_byte_en[1]) begin
        next_st.word[wr_addr][15:8] = wr_data;
      end
    end
    next_st.rd_a = (rd_a_addr < 4'(NUM_TEMPS)) ? st.word[rd_a_addr] : 16'h0000;
    next_st.rd_b = (rd_b_addr < 4'(NUM_TEMPS)) ? st.word[rd_b_addr] : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= MEM_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rd_a_data = st.rd_a;
  assign rd_b_data = st.rd_b;

endmodule // limit_mem
`default_nettype wire

// [design/alert_hub.sv]
`timescale 1ns/1ns
`default_nettype none
module alert_hub (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // serial register bus, open drain data
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_n,
  // temperature readings from the decoder, one channel at a time
  input  wire logic                          temp_valid,
  input  wire logic [3:0]                    temp_chan,
  input  wire logic [7:0]                    temp_value,
  // fan and threshold conditions from the tach logic
  input  wire logic [alert_pkg::NUM_FANS-1:0] fan_out_of_limit,
  input  wire logic                          below_fan_on_threshold,
  // alert and fan drive
  output logic                               alert_n,
  output logic [alert_pkg::NUM_FANS-1:0]     pwm_out
);
  import alert_pkg::*;

  typedef struct packed {
    logic [2:0]                 scl_sync;
    logic [2:0]                 sda_sync;
    bus_state_t                 fsm;
    logic [3:0]                 bit_cnt;
    logic [7:0]                 shift;
    logic [7:0]                 tx;
    logic [7:0]                 ptr;
    logic                       rw;
    logic                       first;
    logic                       sda_oe_n;
    logic [7:0]                 config1;
    logic [7:0]                 mask1;
    logic [7:0]                 mask2;
    logic [7:0]                 pwm_cfg;
    logic [NUM_FANS-1:0][7:0]   duty;
    logic [6:0]                 status1;
    logic [7:0]                 status2;
    logic [NUM_TEMPS-1:0]       temp_oor;
    logic                       cmp_pend;
    logic [3:0]                 cmp_chan;
    logic [7:0]                 cmp_val;
    logic [7:0]                 pwm_cnt;
    logic [7:0]                 pwm_div;
    logic [NUM_FANS-1:0]        pwm;
    logic                       alert_n;
  } hub_state_t;

  localparam hub_state_t ST_RESET = '{scl_sync: 3'h7,
                                      sda_sync: 3'h7,
                                      fsm:      BUS_IDLE,
                                      sda_oe_n: 1'h1,
                                      config1:  CONFIG1_RESET,
                                      mask1:    MASK_RESET,
                                      mask2:    MASK_RESET,
                                      pwm_cfg:  PWM_CFG_RESET,
                                      duty:     {NUM_FANS{PWM_DUTY_RESET}},
                                      alert_n:  1'h1,
                                      default:  '0};

  hub_state_t  st;
  hub_state_t  next_st;

  logic        scl;
  logic        scl_prev;
  logic        sda;
  logic        sda_prev;
  logic        bus_start;
  logic        bus_stop;
  logic        scl_rise;
  logic        scl_fall;
  logic        load_tx;
  logic        write_reg;
  logic        rd_status1;
  logic        rd_status2;
  logic        monitoring;
  logic [7:0]  rd_val;
  logic [7:0]  lim_idx;
  logic [7:0]  pwm_idx;
  logic [6:0]  cond1;
  logic [7:0]  cond2;
  logic [6:0]  pend1;
  logic [7:0]  pend2;
  logic        mem_wr;
  logic [15:0] lim_cmp;
  logic [15:0] lim_host;

  // limit pairs: low byte at even offsets, high byte at odd offsets
  limit_mem u_limits (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_en      (mem_wr),
    .wr_addr    (lim_idx[4:1]),
    .wr_byte_en ({lim_idx[0], ~lim_idx[0]}),
    .wr_data    (st.shift),
    .rd_a_addr  (temp_chan),
    .rd_a_data  (lim_cmp),
    .rd_b_addr  (lim_idx[4:1]),
    .rd_b_data  (lim_host)
  );

  // bus edges look only at the second sync stage and its delayed copy
  always_comb begin
    scl       = st.scl_sync[1];
    scl_prev  = st.scl_sync[2];
    sda       = st.sda_sync[1];
    sda_prev  = st.sda_sync[2];
    bus_start = scl && sda_prev && !sda;
    bus_stop  = scl && !sda_prev && sda;
    scl_rise  = scl && !scl_prev;
    scl_fall  = !scl && scl_prev;
    lim_idx   = st.ptr - REG_LIMIT_BASE;
    pwm_idx   = st.ptr - REG_PWM_DUTY_BASE;
  end

  // host read mux; unmapped offsets read as zero
  always_comb begin
    if (st.ptr == REG_CONFIG1) begin
      rd_val = st.config1;
    end else if (st.ptr == REG_STATUS1) begin
      rd_val = {|st.status2, st.status1};
    end else if (st.ptr == REG_STATUS2) begin
      rd_val = st.status2;
    end else if (st.ptr == REG_MASK1) begin
      rd_val = st.mask1;
    end else if (st.ptr == REG_MASK2) begin
      rd_val = st.mask2;
    end else if (st.ptr == REG_PWM_CFG) begin
      rd_val = st.pwm_cfg;
    end else if (in_range(st.ptr, REG_LIMIT_BASE, REG_LIMIT_LAST)) begin
      rd_val = lim_idx[0] ? lim_host[15:8] : lim_host[7:0];
    end else if (in_range(st.ptr, REG_PWM_DUTY_BASE, REG_PWM_DUTY_LAST)) begin
      rd_val = st.duty[pwm_idx[1:0]];
    end else begin
      rd_val = 8'h00;
    end
  end

  // next state of the whole block
  always_comb begin
    next_st    = st;
    load_tx    = 1'h0;
    write_reg  = 1'h0;
    rd_status1 = 1'h0;
    rd_status2 = 1'h0;
    mem_wr     = 1'h0;
    next_st.scl_sync = {st.scl_sync[1:0], scl_in};
    next_st.sda_sync = {st.sda_sync[1:0], sda_in};

    // serial slave; start and stop win over any state
    if (bus_start) begin
      next_st.fsm      = BUS_ADDR;
      next_st.bit_cnt  = 4'h0;
      next_st.sda_oe_n = 1'h1;
    end else if (bus_stop) begin
      next_st.fsm      = BUS_IDLE;
      next_st.sda_oe_n = 1'h1;
    end else begin
      case (st.fsm)
        BUS_ADDR, BUS_WR_BYTE: begin
          if (scl_rise) begin
            next_st.shift   = {st.shift[6:0], sda};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall && (st.bit_cnt == 4'h8)) begin
            if (st.fsm == BUS_WR_BYTE) begin
              next_st.sda_oe_n = 1'h0;
              next_st.fsm      = BUS_WR_ACK;
              next_st.first    = 1'h0;
              if (st.first) begin
                next_st.ptr = st.shift;
              end else begin
                write_reg = 1'h1;
              end
            end else if (st.shift[7:1] == DEVICE_ADDR) begin
              next_st.sda_oe_n = 1'h0;
              next_st.rw       = st.shift[0];
              next_st.fsm      = BUS_ADDR_ACK;
            end else begin
              next_st.fsm = BUS_IDLE; // another device is addressed
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe_n = 1'h1;
            next_st.bit_cnt  = 4'h0;
            if (st.rw) begin
              load_tx = 1'h1;
            end else begin
              next_st.fsm   = BUS_WR_BYTE;
              next_st.first = 1'h1;
            end
          end
        end
        BUS_WR_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe_n = 1'h1;
            next_st.bit_cnt  = 4'h0;
            next_st.fsm      = BUS_WR_BYTE;
          end
        end
        BUS_RD_BYTE: begin
          if (scl_fall) begin
            if (st.bit_cnt == 4'h8) begin
              next_st.sda_oe_n = 1'h1;
              next_st.fsm      = BUS_RD_ACK;
              next_st.ptr      = st.ptr + 8'h01;
            end else begin
              next_st.sda_oe_n = st.tx[6];
              next_st.tx       = {st.tx[6:0], 1'h0};
              next_st.bit_cnt  = st.bit_cnt + 4'h1;
            end
          end
        end
        BUS_RD_ACK: begin
          if (scl_rise) begin
            next_st.fsm = sda ? BUS_IDLE : BUS_RD_NEXT; // nack ends read
          end
        end
        BUS_RD_NEXT: begin
          if (scl_fall) begin
            load_tx = 1'h1;
          end
        end
        default: begin
          next_st.sda_oe_n = 1'h1;
        end
      endcase
    end

    // first data bit goes out with the byte; this is the read event
    if (load_tx) begin
      next_st.tx       = rd_val;
      next_st.sda_oe_n = rd_val[7];
      next_st.bit_cnt  = 4'h1;
      next_st.fsm      = BUS_RD_BYTE;
      rd_status1       = (st.ptr == REG_STATUS1);
      rd_status2       = (st.ptr == REG_STATUS2);
    end

    // register writes; status registers ignore writes
    if (write_reg) begin
      next_st.ptr = st.ptr + 8'h01;
      if (st.ptr == REG_CONFIG1) begin
        next_st.config1 = st.shift;
      end else if (st.ptr == REG_MASK1) begin
        next_st.mask1 = st.shift;
      end else if (st.ptr == REG_MASK2) begin
        next_st.mask2 = st.shift;
      end else if (st.ptr == REG_PWM_CFG) begin
        next_st.pwm_cfg = st.shift;
      end else if (in_range(st.ptr, REG_LIMIT_BASE, REG_LIMIT_LAST)) begin
        mem_wr = 1'h1;
      end else if (in_range(st.ptr, REG_PWM_DUTY_BASE,
                            REG_PWM_DUTY_LAST)) begin
        next_st.duty[pwm_idx[1:0]] = st.shift;
      end
    end

    // limit check one cycle after the reading, once the limits are out
    monitoring       = st.config1[CFG_START_BIT];
    next_st.cmp_pend = temp_valid;
    next_st.cmp_chan = temp_chan;
    next_st.cmp_val  = temp_value;
    if (!monitoring) begin
      next_st.temp_oor = '0;
    end else if (st.cmp_pend && (st.cmp_chan < 4'(NUM_TEMPS))) begin
      next_st.temp_oor[st.cmp_chan] =
        limit_fail(st.cmp_val, lim_cmp[15:8], lim_cmp[7:0]);
    end

    // sticky flags: a live condition beats the read that would clear it
    cond1 = st.temp_oor[6:0] & {7{monitoring}};
    cond2 = {fan_out_of_limit, below_fan_on_threshold, st.temp_oor[9:7]} &
            {8{monitoring}};
    next_st.status1 = cond1 | (st.status1 & ~{7{rd_status1}});
    next_st.status2 = cond2 | (st.status2 & ~{8{rd_status2}});

    // masks gate only the alert, never the flags
    pend1 = st.status1 & ~st.mask1[6:0];
    pend2 = st.status2 & ~st.mask2 &
            {8{~st.mask1[MASK1_STATUS2_BIT]}};
    next_st.alert_n = !((|pend1) || (|pend2));

    // fan pwm: full rate gives 39 kHz, divided rate about 1.4 kHz
    if (!st.pwm_cfg[PWM_CFG_LOW_FREQ_BIT] ||
        (st.pwm_div == PWM_LOW_DIV - 8'h01)) begin
      next_st.pwm_div = 8'h00;
      next_st.pwm_cnt = st.pwm_cnt + 8'h01;
    end else begin
      next_st.pwm_div = st.pwm_div + 8'h01;
    end
    for (int i = 0; i < NUM_FANS; i++) begin
      next_st.pwm[i] = st.pwm_cnt < st.duty[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // open drain: the data level is always low, the enable decides
  assign sda_out  = 1'h0;
  assign sda_oe_n = st.sda_oe_n;
  assign alert_n  = st.alert_n;
  assign pwm_out  = st.pwm;

endmodule // alert_hub
`default_nettype wire

// [sim/alert_hub_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module alert_hub_properties (
  // clock and reset
  input wire logic                           clk_sys,
  input wire logic                           rst_n,
  // bus pins
  input wire logic                           scl_in,
  input wire logic                           sda_oe_n,
  // alert sources
  input wire logic                           temp_valid,
  input wire logic [alert_pkg::NUM_FANS-1:0] fan_out_of_limit,
  input wire logic                           below_fan_on_threshold,
  // outputs
  input wire logic                           alert_n,
  input wire logic [alert_pkg::NUM_FANS-1:0] pwm_out
);
  import alert_pkg::*;
  // fall, drive and gap counters saturate so long idle spans never wrap into a false match
  logic [7:0] fall_cnt;
  logic [7:0] oe_cnt;
  logic [8:0] gap;
  logic [8:0] hi_cnt;
  logic       scl_q;
  logic       pwm_q;
  logic       rise_seen;
  logic       cause_seen;
  // history of bus clock falls, data drive and pwm edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt   <= 8'hFF;
      oe_cnt     <= 8'hFF;
      gap        <= 9'h000;
      hi_cnt     <= 9'h000;
      scl_q      <= 1'b1;
      pwm_q      <= 1'b0;
      rise_seen  <= 1'b0;
      cause_seen <= 1'b0;
    end else begin
      scl_q      <= scl_in;
      pwm_q      <= pwm_out[0];
      fall_cnt   <= (scl_q && !scl_in) ? 8'h00
                    : fall_cnt + {7'h00, fall_cnt != 8'hFF};
      oe_cnt     <= !sda_oe_n ? 8'h00 : oe_cnt + {7'h00, oe_cnt != 8'hFF};
      gap        <= (pwm_out[0] && !pwm_q) ? 9'h001
                    : gap + {8'h00, gap != 9'h1FF};
      hi_cnt     <= pwm_out[0] ? hi_cnt + 9'h001 : 9'h000;
      rise_seen  <= rise_seen | (pwm_out[0] && !pwm_q);
      cause_seen <= cause_seen | temp_valid | below_fan_on_threshold
                    | (|fan_out_of_limit);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // only a bus read or mask write may release alert, so a clock fall leads
  property p_rise_near_bus; $rose(alert_n) |-> fall_cnt <= 8'h08; endproperty
  a_rise_near_bus: assert property (p_rise_near_bus)
    else $error("alert released with no bus clock fall just before");
  property p_rise_after_ack; $rose(alert_n) |-> oe_cnt < 8'h20; endproperty
  a_rise_after_ack: assert property (p_rise_after_ack)
    else $error("alert released with no recent bus transfer");
  property p_idle_holds; (scl_in && !alert_n) [*8] |=> !alert_n; endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("alert released while the bus was idle");
  property p_fall_has_cause; $fell(alert_n) |-> cause_seen; endproperty
  a_fall_has_cause: assert property (p_fall_has_cause)
    else $error("alert asserted with no source ever active");
  property p_reset_quiet;
    $rose(rst_n) |-> alert_n && sda_oe_n && !(|pwm_out);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset release");
  // pwm checks hold while duty and rate stay at reset values
  property p_pwm_period; $rose(pwm_out[0]) && rise_seen |-> gap == 9'h100;
  endproperty
  a_pwm_period: assert property (p_pwm_period)
    else $error("fan drive period is not 256 clocks");
  property p_pwm_high; $fell(pwm_out[0]) |-> hi_cnt == 9'h080; endproperty
  a_pwm_high: assert property (p_pwm_high)
    else $error("fan drive on time is not 128 clocks");
  property p_pwm_step; $rose(pwm_out[0]) |-> (&pwm_out) [*8]; endproperty
  a_pwm_step: assert property (p_pwm_step)
    else $error("fan drive channels out of step");
  c_alert_on: cover property ($fell(alert_n));
  c_alert_off: cover property ($rose(alert_n));
  c_ack: cover property ($fell(sda_oe_n));
endmodule // alert_hub_properties
bind alert_hub alert_hub_properties u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .temp_valid(temp_valid), .fan_out_of_limit(fan_out_of_limit),
  .below_fan_on_threshold(below_fan_on_threshold), .alert_n(alert_n),
  .pwm_out(pwm_out)
);
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input  wire logic clk_sys,
  // bus pins, sda_pull high pulls data low
  output var  logic scl,
  output var  logic sda_pull,
  input  wire logic sda
);
  import alert_pkg::*;
  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bit: low 8 clocks, data moves mid-low, high 6 clocks
  task automatic clk_bit(input logic pull, output logic seen);
    scl <= 1'b0;
    tick(4);
    sda_pull <= pull;
    tick(4);
    scl <= 1'b1;
    tick(5);
    seen = sda;
    tick(1);
  endtask
  // data falls while clock high; also serves as repeated start
  task automatic frame_start();
    logic x;
    clk_bit(1'b0, x);
    sda_pull <= 1'b1;
    tick(6);
  endtask
  task automatic frame_stop();
    logic x;
    clk_bit(1'b1, x);
    sda_pull <= 1'b0;
    tick(6);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) clk_bit(~b[i], x);
    clk_bit(1'b0, x);
    ack = ~x;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic k0, k1, k2;
    frame_start();
    put({DEVICE_ADDR, 1'b0}, k0);
    put(a, k1);
    put(d, k2);
    frame_stop();
    ok = k0 & k1 & k2;
  endtask
  // single byte read, ended by a released ack
  task automatic rd(input logic [7:0] a, output logic [7:0] q,
                    output logic ok);
    logic k0, k1, k2, x;
    frame_start();
    put({DEVICE_ADDR, 1'b0}, k0);
    put(a, k1);
    frame_start();
    put({DEVICE_ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, q[i]);
    clk_bit(1'b0, x);
    frame_stop();
    ok = k0 & k1 & k2;
  endtask
endmodule // host_model
`default_nettype wire

// [sim/alert_hub_test.sv]
`timescale 1ns/1ns
`default_nettype none
module alert_hub_test;
  import alert_pkg::*;
  // about 50k clocks expected; margin for a slow but legal design
  localparam int LIMIT = 80000;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  logic                scl;
  logic                sda_pull;
  wire  logic          sda;
  logic                sda_out;
  logic                sda_oe_n;
  logic                temp_valid = 1'b0;
  logic [3:0]          temp_chan = 4'h0;
  logic [7:0]          temp_value = 8'h00;
  logic [NUM_FANS-1:0] fan_out_of_limit = {NUM_FANS{1'b0}};
  logic                below_fan_on_threshold = 1'b0;
  logic                alert_n;
  logic [NUM_FANS-1:0] pwm_out;
  int                  bad_count = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  always #50 clk_sys = ~clk_sys;
  // open drain data: either side pulls low, pull-up otherwise
  assign sda = (sda_oe_n ? 1'b1 : sda_out) & ~sda_pull;
  alert_hub dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .temp_valid(temp_valid),
    .temp_chan(temp_chan), .temp_value(temp_value),
    .fan_out_of_limit(fan_out_of_limit),
    .below_fan_on_threshold(below_fan_on_threshold),
    .alert_n(alert_n), .pwm_out(pwm_out)
  );
  host_model host (
    .clk_sys(clk_sys), .scl(scl), .sda_pull(sda_pull), .sda(sda)
  );
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic alert(input logic exp);
    chk_pin("alert_n", exp, alert_n);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    chk_pin("write ack", 1'b1, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic       ok;
    logic [7:0] q;
    host.rd(a, q, ok);
    chk_pin("read ack", 1'b1, ok);
    chk_byte($sformatf("register %h", a), exp, q);
  endtask
  // source s: 0..9 temps (reading v), 10 threshold, 11.. fans
  task automatic cond(input int s, input logic on, input logic [7:0] v);
    @(posedge clk_sys);
    if (s < 10) begin
      temp_valid <= 1'b1;
      temp_chan  <= 4'(s);
      temp_value <= v;
    end else if (s == 10) begin
      below_fan_on_threshold <= on;
    end else begin
      fan_out_of_limit[s-11] <= on;
    end
    @(posedge clk_sys);
    temp_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    logic [7:0] b;
    logic [7:0] ma;
    logic [7:0] sa;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    alert(1'b1);
    rd(REG_MASK1, MASK_RESET);
    rd(REG_MASK2, MASK_RESET);
    rd(8'h7F, 8'h00);
    // fan drive settings come up at full rate and half duty
    rd(REG_PWM_CFG, PWM_CFG_RESET);
    rd(REG_PWM_DUTY_BASE, PWM_DUTY_RESET);
    // a fault before monitoring starts leaves no flag
    cond(0, 1'b1, 8'h80);
    alert(1'b1);
    rd(REG_STATUS1, 8'h00);
    wr(REG_LIMIT_BASE, 8'h10);
    wr(REG_LIMIT_BASE + 8'h01, 8'h50);
    rd(REG_LIMIT_BASE + 8'h01, 8'h50);
    wr(REG_CONFIG1, 8'h01);
    // limit edges: high strictly above, low includes equality
    cond(0, 1'b1, 8'h50);
    alert(1'b1);
    cond(0, 1'b1, 8'h11);
    alert(1'b1);
    cond(0, 1'b1, 8'h10);
    alert(1'b0);
    rd(REG_STATUS1, 8'h01);
    alert(1'b0);
    cond(0, 1'b0, 8'h20);
    alert(1'b0);
    rd(REG_STATUS1, 8'h01);
    alert(1'b1);
    rd(REG_STATUS1, 8'h00);
    // summary mask hides second-status sources, flags still set
    wr(REG_MASK1, 8'h80);
    rd(REG_MASK1, 8'h80);
    cond(10, 1'b1, 8'h00);
    alert(1'b1);
    rd(REG_STATUS1, 8'h80);
    rd(REG_STATUS2, 8'h08);
    wr(REG_MASK1, 8'h00);
    alert(1'b0);
    cond(10, 1'b0, 8'h00);
    rd(REG_STATUS2, 8'h08);
    alert(1'b1);
    rd(REG_STATUS1, 8'h00);
    // each source: alert, read, mask, poll, unmask
    for (int s = 0; s < 15; s++) begin
      b  = (s < 7) ? 8'h01 << s : (s < 10) ? 8'h01 << (s - 7)
           : (s == 10) ? 8'h08 : 8'h10 << (s - 11);
      ma = (s < 7) ? REG_MASK1 : REG_MASK2;
      sa = (s < 7) ? REG_STATUS1 : REG_STATUS2;
      cond(s, 1'b1, 8'h80);
      alert(1'b0);
      rd(sa, b);
      wr(ma, b);
      alert(1'b1);
      cond(s, 1'b0, 8'h20);
      rd(sa, b);
      rd(sa, 8'h00);
      wr(ma, 8'h00);
      alert(1'b1);
    end
    end_sim();
  end
endmodule // alert_hub_test
`default_nettype wire
